// File: energy_mode_power_domain_ctrl.sv
// energy mode power domain controller with wishbone registers
// What this block does
// - keep separate scaling choices for active/sleep and for deep sleep/stop.
// - active/sleep scaling resets to the highest level.
// - lowest scaling accepted only for the deep sleep/stop choice.
// - regulator target follows the scaling choice of the current mode by itself.
// - low buck input supply sets a sticky flag raising an interrupt.
// - buck ramps gradually at boot and when going into bypass.
// - domain power switching is done here, no software sequencing needed.
// - always-on domain powered in every mode including shutoff.
// - shutoff removes power from base and all auxiliary low-power domains.
// - base low-power domain powered in active, sleep, deep sleep, stop.
// - in deep sleep/stop each of the first three auxiliary domains is on only if its peripherals are.
// - fourth auxiliary domain on whenever any of the first three is used.
// - active domain always powered in active and sleep.
// - active domain off in deep sleep, stop and shutoff.
// - peripherals on no low-power domain count as active-domain peripherals.
// - in deep sleep/stop only ports A and B keep digital pin functions.
`timescale 1ns/100ps
`include "pwr_cfg.svh"

module energy_mode_power_domain_ctrl
    import pwr_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_clk_en,
    input  wire logic [2:0]  i_energy_mode,
    input  wire logic [3:0]  i_aux_periph_en,
    input  wire logic        i_buck_low_supply,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic      [1:0]  o_scale_target,
    output logic             o_always_on_domain_en,
    output logic             o_base_low_power_domain_en,
    output logic      [3:0]  o_aux_domain_en,
    output logic             o_active_domain_en,
    output logic             o_ports_cd_en,
    output logic             o_buck_bypass,
    output logic      [7:0]  o_buck_soft_level,
    output logic             o_irq
);
    // =================================================================
    // reset release and input synchronisers
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // mode and enables arrive from the sequencer domain pins
    logic [2:0] mode_s1_r;
    logic [2:0] mode_s2_r;
    logic [3:0] pen_s1_r;
    logic [3:0] pen_s2_r;
    logic       low_s1_r;
    logic       low_s2_r;
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s1_r <= 3'h0;
            mode_s2_r <= 3'h0;
            pen_s1_r  <= 4'h0;
            pen_s2_r  <= 4'h0;
            low_s1_r  <= 1'b0;
            low_s2_r  <= 1'b0;
        end else if (i_clk_en) begin
            mode_s1_r <= i_energy_mode;
            mode_s2_r <= mode_s1_r;
            pen_s1_r  <= i_aux_periph_en;
            pen_s2_r  <= pen_s1_r;
            low_s1_r  <= i_buck_low_supply;
            low_s2_r  <= low_s1_r;
        end
    end

    // =================================================================
    // mode filter: a code is taken only after two equal samples, so a
    // code caught between its bit changes never reaches a domain switch
    logic [2:0] mode_s3_r;
    logic [2:0] mode_q_r;
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s3_r <= 3'h0;
            mode_q_r  <= 3'h0;
        end else if (i_clk_en) begin
            mode_s3_r <= mode_s2_r;
            if (mode_s2_r == mode_s3_r) begin
                mode_q_r <= mode_s3_r;
            end
        end
    end

    // =================================================================
    // mode decode
    energy_mode_t mode;
    logic         run_mode;
    logic         low_mode;
    always_comb begin
        unique case (mode_q_r)
            3'h1:    mode = sleep_mode;
            3'h2:    mode = deep_sleep_mode;
            3'h3:    mode = stop_mode;
            3'h4:    mode = shutoff_mode;
            default: mode = active_mode;
        endcase
    end
    assign run_mode = (mode == active_mode) || (mode == sleep_mode);
    assign low_mode = (mode == deep_sleep_mode) || (mode == stop_mode);

    // =================================================================
    // wishbone slave: one-cycle ack, dropped the cycle after
    logic        wb_req;
    logic        wb_wr;
    logic [1:0]  scale_run_r;
    logic [1:0]  scale_low_r;
    logic [1:0]  irq_flags_r;
    logic [1:0]  irq_mask_r;
    logic        bypass_req_r;
    buck_state_t buck_r;
    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wb_wr  = wb_req && i_wb_we && i_wb_sel[0];

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else if (i_clk_en) begin
            o_wb_ack <= wb_req;
            if (wb_req && !i_wb_we) begin
                case (i_wb_adr)
                    `REG_SCALE_RUN: o_wb_dat <= {30'h0, scale_run_r};
                    `REG_SCALE_LOW: o_wb_dat <= {30'h0, scale_low_r};
                    `REG_STATUS:    o_wb_dat <= {24'h0, buck_r, 1'b0, mode_q_r};
                    `REG_IRQ_FLAGS: o_wb_dat <= {30'h0, irq_flags_r};
                    `REG_IRQ_MASK:  o_wb_dat <= {30'h0, irq_mask_r};
                    `REG_BUCK_CTRL: o_wb_dat <= {31'h0, bypass_req_r};
                    default:        o_wb_dat <= 32'h0;
                endcase
            end
        end
    end

    // =================================================================
    // scaling selections
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scale_run_r <= `SCALE_RUN_RST;
            scale_low_r <= `SCALE_LOW_RST;
        end else if (i_clk_en && wb_wr) begin
            // run choice refuses the lowest level and unused codes
            if (i_wb_adr == `REG_SCALE_RUN &&
                (i_wb_dat[1:0] == scale_level_mid || i_wb_dat[1:0] == scale_level_high)) begin
                scale_run_r <= i_wb_dat[1:0];
            end
            if (i_wb_adr == `REG_SCALE_LOW && i_wb_dat[1:0] != 2'h3) begin
                scale_low_r <= i_wb_dat[1:0];
            end
        end
    end

    // software must keep the core clock at 40 MHz or less on mid level
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_scale_target <= `SCALE_RUN_RST;
        end else if (i_clk_en) begin
            o_scale_target <= low_mode ? scale_low_r : scale_run_r;
        end
    end

    // =================================================================
    // domain switching, recomputed every cycle; a mode change acts one cycle after the filter takes it
    // aux enables are independent bits, so each one is synchronised on its own
    logic [2:0] aux_used;
    assign aux_used = low_mode ? pen_s2_r[2:0] : (run_mode ? 3'h7 : 3'h0);
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_always_on_domain_en      <= 1'b1;
            o_base_low_power_domain_en <= 1'b1;
            o_aux_domain_en            <= 4'hF;
            o_active_domain_en         <= 1'b1;
            o_ports_cd_en              <= 1'b1;
        end else if (i_clk_en) begin
            o_always_on_domain_en      <= 1'b1;
            o_base_low_power_domain_en <= run_mode || low_mode;
            o_aux_domain_en[2:0]       <= aux_used;
            o_aux_domain_en[3]         <= (|aux_used) || run_mode ||
                                          (low_mode && pen_s2_r[3]);
            // unlisted peripherals live here, so they follow this enable
            o_active_domain_en         <= run_mode;
            o_ports_cd_en              <= run_mode;
        end
    end

    // =================================================================
    // buck converter soft switching
    logic [7:0] step_cnt_r;
    logic       step_tick;
    logic       soft_done;
    assign step_tick = (step_cnt_r == 8'(`SOFT_STEP_CYC - 1));
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_req_r <= 1'b0;
        end else if (i_clk_en && wb_wr && i_wb_adr == `REG_BUCK_CTRL) begin
            bypass_req_r <= i_wb_dat[`BUCK_BYPASS_BIT];
        end
    end
    // free-running tick: a ramp may start mid-step, so its first step can come early
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt_r <= 8'h0;
        end else if (i_clk_en) begin
            step_cnt_r <= step_tick ? 8'h0 : step_cnt_r + 8'h1;
        end
    end
    // boot ramps up; into bypass ramps down; leaving bypass restarts the boot ramp
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buck_r            <= buck_boot;
            o_buck_soft_level <= 8'h0;
            o_buck_bypass     <= 1'b0;
        end else if (i_clk_en) begin
            unique case (buck_r)
                buck_boot: begin
                    if (step_tick) begin
                        o_buck_soft_level <= o_buck_soft_level + 8'h1;
                        if (o_buck_soft_level == `SOFT_LEVEL_MAX - 8'h1) begin
                            buck_r <= buck_regulate;
                        end
                    end
                end
                buck_regulate: begin
                    if (bypass_req_r) begin
                        buck_r <= buck_ramp_down;
                    end
                end
                buck_ramp_down: begin
                    if (step_tick) begin
                        o_buck_soft_level <= o_buck_soft_level - 8'h1;
                        if (o_buck_soft_level == 8'h1) begin
                            buck_r        <= buck_bypass;
                            o_buck_bypass <= 1'b1;
                        end
                    end
                end
                buck_bypass: begin
                    if (!bypass_req_r) begin
                        buck_r        <= buck_boot;
                        o_buck_bypass <= 1'b0;
                    end
                end
                default: buck_r <= buck_boot;
            endcase
        end
    end
    assign soft_done = (buck_r == buck_ramp_down) && step_tick &&
                       (o_buck_soft_level == 8'h1);

    // =================================================================
    // interrupts: set wins over write-one-to-clear
    logic low_prev_r;
    logic low_rise;
    assign low_rise = low_s2_r && !low_prev_r;
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_prev_r  <= 1'b0;
            irq_flags_r <= 2'h0;
            irq_mask_r  <= `IRQ_MASK_RST;
            o_irq       <= 1'b0;
        end else if (i_clk_en) begin
            low_prev_r <= low_s2_r;
            if (wb_wr && i_wb_adr == `REG_IRQ_MASK) begin
                irq_mask_r <= i_wb_dat[1:0];
            end
            irq_flags_r <= (irq_flags_r &
                            ~((wb_wr && i_wb_adr == `REG_IRQ_FLAGS) ? i_wb_dat[1:0] : 2'h0))
                           | {soft_done, low_rise};
            o_irq <= |(irq_flags_r & irq_mask_r);
        end
    end

    // =================================================================
    // checks: domain switching
    a_shutoff_domains: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && mode == shutoff_mode) |=>
        (!o_base_low_power_domain_en && o_aux_domain_en == 4'h0))
        else $error("shutoff left a low-power domain on");
    a_always_on_held: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        o_always_on_domain_en)
        else $error("always-on domain dropped");
    a_base_on_run: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && (run_mode || low_mode)) |=> o_base_low_power_domain_en)
        else $error("base domain off in a live mode");
    a_aux_follow_en: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && low_mode) |=> (o_aux_domain_en[2:0] == $past(pen_s2_r[2:0])))
        else $error("aux domain not following enables");
    a_aux_four_tied: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && |aux_used) |=> o_aux_domain_en[3])
        else $error("fourth aux domain off while others used");
    a_aux_run_on: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && run_mode) |=> (o_aux_domain_en == 4'hF))
        else $error("aux domain off in a run mode");
    a_active_dom_mode: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        i_clk_en |=> (o_active_domain_en == $past(run_mode)))
        else $error("active domain wrong for mode");
    a_ports_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && low_mode) |=> !o_ports_cd_en)
        else $error("ports beyond A and B live in low mode");
    a_ports_run: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && run_mode) |=> o_ports_cd_en)
        else $error("ports beyond A and B dead in a run mode");
    a_mode_glitch_free: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $changed(mode_q_r) |-> $past(mode_s2_r == mode_s3_r))
        else $error("mode taken from a single sample");

    // checks: scaling
    a_scale_follow: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && low_mode) |=> (o_scale_target == $past(scale_low_r)))
        else $error("scale target not the low-mode choice");
    a_scale_run_follow: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && !low_mode) |=> (o_scale_target == $past(scale_run_r)))
        else $error("scale target not the run choice");
    a_run_no_low: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        scale_run_r != scale_level_low)
        else $error("run scaling at lowest level");
    a_low_no_three: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        scale_low_r != 2'h3)
        else $error("low scaling holds an unused code");

    // checks: bus, interrupts and buck
    a_ack_pulse: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && o_wb_ack) |=> !o_wb_ack)
        else $error("bus ack held longer than one cycle");
    a_low_flag_set: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && low_rise) |=> irq_flags_r[`IRQ_LOW_SUPPLY])
        else $error("low supply flag not set");
    a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        i_clk_en |=> (o_irq == $past(|(irq_flags_r & irq_mask_r))))
        else $error("interrupt output not the masked flags");
    a_bypass_soft: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(o_buck_bypass) |-> (o_buck_soft_level == 8'h0))
        else $error("bypass entered before ramp finished");
    a_ramp_one_step: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && !step_tick) |=> $stable(o_buck_soft_level))
        else $error("soft level moved between ramp steps");
    a_clk_en_freeze: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
        !i_clk_en |=> ($stable(o_aux_domain_en) && $stable(o_scale_target) &&
                       $stable(o_buck_soft_level) && $stable(o_irq)))
        else $error("state moved while the clock enable was low");

    // cover points
    c_shutoff: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        mode == shutoff_mode);
    c_low_aux: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        low_mode && o_aux_domain_en[3]);
    c_bypass: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(o_buck_bypass));
    c_irq: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        $rose(o_irq));
    c_clk_en_stall: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
        !i_clk_en ##1 i_clk_en);
endmodule

// File: energy_mode_power_domain_ctrl_tb.sv
// self-checking bench for the energy mode power domain controller
`timescale 1ns/100ps
`include "pwr_cfg.svh"

module energy_mode_power_domain_ctrl_tb
    import pwr_pkg::*;
;
logic        clk = 1'b0;
logic        rstn = 1'b0;
logic        clk_en = 1'b1;
logic        cyc = 1'b0;
logic        stb = 1'b0;
logic        we = 1'b0;
logic [7:0]  adr = 8'h00;
logic [3:0]  sel = 4'h0;
logic [31:0] wdat = 32'h0;
logic [31:0] rdat;
logic        ack;
logic [1:0]  scale;
logic        aon, base, act, ports, byp, irq;
logic [3:0]  aux;
logic [7:0]  lvl;
logic [2:0]  mreq = 3'h0;
logic [3:0]  areq = 4'h0;
logic        lreq = 1'b0;
logic [2:0]  mode;
logic [3:0]  aen;
logic        low;
logic [1:0]  div;
int          errors = 0;
int          cmp_count = 0;

energy_mode_power_domain_ctrl DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(clk_en),
    .i_energy_mode(mode), .i_aux_periph_en(aen), .i_buck_low_supply(low),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_scale_target(scale),
    .o_always_on_domain_en(aon), .o_base_low_power_domain_en(base),
    .o_aux_domain_en(aux), .o_active_domain_en(act), .o_ports_cd_en(ports),
    .o_buck_bypass(byp), .o_buck_soft_level(lvl), .o_irq(irq));

far_side_model partner (.i_ref_clk(clk), .i_mode_req(mreq), .i_aux_req(areq),
    .i_low_req(lreq), .i_scale_target(scale), .o_energy_mode(mode),
    .o_aux_periph_en(aen), .o_buck_low_supply(low), .o_core_div(div));

initial begin
    forever #5 clk = ~clk;
end
// =====================================================================
// checking and bus tasks
task automatic test_done();
    if (errors == 0 && cmp_count > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
        errors++;
        $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
endtask

task automatic limit(input int n);
    if (n >= 4000) begin
        errors++;
        test_done();
    end
endtask

task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                  output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
        @(posedge clk);
        n++;
    end while (ack !== 1'b1 && n < 4000);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    limit(n);
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
endtask

task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
endtask

// expected enables: {always on, base, aux[3:0], active, ports c/d}
function automatic logic [31:0] exp_dom(input logic [2:0] m, input logic [3:0] a);
    case (m)
        3'h2, 3'h3: return {24'h0, 2'h3, |a, a[2:0], 2'h0};
        3'h4: return 32'h80;
        default: return 32'hFF;
    endcase
endfunction
// =====================================================================
// main sequence
logic [2:0]  cm [8] = '{3'h2, 3'h3, 3'h4, 3'h2, 3'h3, 3'h5, 3'h7, 3'h1};
logic [3:0]  ca [8] = '{4'h0, 4'h8, 4'hF, 4'h1, 4'h2, 4'h4, 4'hF, 4'h0};
initial begin
    logic [31:0] q;
    logic [7:0]  l0;
    logic [2:0]  m;
    logic [3:0]  a;
    logic [1:0]  run_s;
    int          n;
    void'($urandom(32'hA2B97B95));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`REG_SCALE_RUN, q); chk("scale_run", 32'h2, q);
    rd(`REG_SCALE_LOW, q); chk("scale_low", 32'h2, q);
    rd(`REG_IRQ_MASK, q); chk("irq_mask", 32'h0, q);
    chk("scale_target", 32'h2, scale);
    l0 = lvl;
    repeat (100) @(posedge clk);
    chk("ramp_step", 32'h1, (lvl - l0 >= 8'd9) && (lvl - l0 <= 8'd11));
    // zero and three are refused for the run choice, three for the low choice
    wr(`REG_SCALE_RUN, 32'h1);
    wr(`REG_SCALE_LOW, 32'h0);
    wr(`REG_SCALE_RUN, 32'h0);
    wr(`REG_SCALE_RUN, 32'h3);
    wr(`REG_SCALE_LOW, 32'h3);
    rd(`REG_SCALE_RUN, q); chk("scale_run", 32'h1, q);
    rd(`REG_SCALE_LOW, q); chk("scale_low", 32'h0, q);
    rd(8'h20, q); chk("unmapped", 32'h0, q);
    run_s = 2'h1;
    for (int i = 0; i < 48; i++) begin
        if (i < 8) begin
            m = cm[i];
            a = ca[i];
        end else begin
            m = 3'($urandom_range(7, 0));
            a = 4'($urandom_range(15, 0));
        end
        if (i == 24) begin
            wr(`REG_SCALE_RUN, 32'h2);
            run_s = 2'h2;
        end
        mreq <= m;
        areq <= a;
        repeat (8) @(posedge clk);
        chk("domains", exp_dom(m, a), {aon, base, aux, act, ports});
        chk("scale_target", (m == 3'h2 || m == 3'h3) ? 2'h0 : run_s, scale);
        chk("core_clk", 32'h1, (scale != 2'h1) || (div >= 2'h3));
        rd(`REG_STATUS, q);
        chk("status_mode", m, q & 32'h7);
    end
    // clock enable low freezes the domain enables while the mode pins move
    clk_en <= 1'b0;
    mreq <= 3'h4;
    repeat (8) @(posedge clk);
    chk("frozen", exp_dom(m, a), {aon, base, aux, act, ports});
    clk_en <= 1'b1;
    repeat (8) @(posedge clk);
    chk("domains", exp_dom(3'h4, a), {aon, base, aux, act, ports});
    mreq <= 3'h0;
    // low supply flag: unmasked, then masked, then unmasked late
    wr(`REG_IRQ_MASK, 32'h1);
    lreq <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq", 32'h1, irq);
    rd(`REG_IRQ_FLAGS, q); chk("flags", 32'h1, q & 32'h3);
    lreq <= 1'b0;
    wr(`REG_IRQ_FLAGS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, irq);
    wr(`REG_IRQ_MASK, 32'h0);
    lreq <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq", 32'h0, irq);
    lreq <= 1'b0;
    wr(`REG_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, irq);
    wr(`REG_IRQ_FLAGS, 32'h1);
    // buck: finish boot ramp, then soft ramp down into bypass
    n = 0;
    while (lvl !== 8'hFF && n < 4000) begin
        @(posedge clk);
        n++;
    end
    limit(n);
    chk("bypass", 32'h0, byp);
    wr(`REG_IRQ_MASK, 32'h2);
    wr(`REG_BUCK_CTRL, 32'h1);
    repeat (50) @(posedge clk);
    chk("ramp_down", 32'h1, (lvl >= 8'd248) && (lvl <= 8'd252) && (byp === 1'b0));
    n = 0;
    while (byp !== 1'b1 && n < 4000) begin
        @(posedge clk);
        n++;
    end
    limit(n);
    chk("soft_level", 32'h0, lvl);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, irq);
    rd(`REG_STATUS, q); chk("buck_state", 32'h80, q & 32'hF0);
    wr(`REG_IRQ_FLAGS, 32'h2);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, irq);
    // dropping the bypass request leaves bypass and restarts the boot ramp
    wr(`REG_BUCK_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("bypass_exit", 32'h0, byp);
    rd(`REG_STATUS, q);
    chk("buck_state", 32'h10, q & 32'hF0);
    test_done();
end
endmodule

// File: far_side_model.sv
// far side model: mode sequencer, peripheral enables, supply monitor, core clock
`timescale 1ns/100ps

module far_side_model
    import pwr_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic [2:0] i_mode_req,
    input  wire logic [3:0] i_aux_req,
    input  wire logic       i_low_req,
    input  wire logic [1:0] i_scale_target,
    output logic      [2:0] o_energy_mode = 3'h0,
    output logic      [3:0] o_aux_periph_en = 4'h0,
    output logic            o_buck_low_supply = 1'b0,
    output logic      [1:0] o_core_div
);
// =====================================================================
// sequencer outputs launch just after the edge, one register deep
always @(posedge i_ref_clk) begin
    o_energy_mode     <= i_mode_req;
    o_aux_periph_en   <= i_aux_req;
    o_buck_low_supply <= i_low_req;
end
// core clock divided by three below the high level keeps it near 33 MHz
assign o_core_div = (i_scale_target == scale_level_high) ? 2'h1 : 2'h3;
endmodule

// File: pwr_cfg.svh
// constants for the energy mode power domain controller
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
// =====================================================================
// register byte offsets
`define REG_SCALE_RUN     8'h00
`define REG_SCALE_LOW     8'h04
`define REG_STATUS        8'h08
`define REG_IRQ_FLAGS     8'h0C
`define REG_IRQ_MASK      8'h10
`define REG_BUCK_CTRL     8'h14
// =====================================================================
// reset values and field positions
`define SCALE_RUN_RST     2'h2
`define SCALE_LOW_RST     2'h2
`define IRQ_MASK_RST      2'h0
`define IRQ_LOW_SUPPLY    0
`define IRQ_SOFT_DONE     1
`define BUCK_BYPASS_BIT   0
// =====================================================================
// soft switching ramp: step time and step count
`define SOFT_STEP_NS      100
`define SOFT_STEP_CYC     ((`SOFT_STEP_NS + 9) / 10)
`define SOFT_LEVEL_MAX    8'hFF
`endif

// File: pwr_pkg.sv
// types for the energy mode power domain controller
package pwr_pkg;
    typedef enum logic [2:0] {
        active_mode     = 3'h0,
        sleep_mode      = 3'h1,
        deep_sleep_mode = 3'h2,
        stop_mode       = 3'h3,
        shutoff_mode    = 3'h4
    } energy_mode_t;
    typedef enum logic [1:0] {
        scale_level_low  = 2'h0,
        scale_level_mid  = 2'h1,
        scale_level_high = 2'h2
    } scale_level_t;
    typedef enum logic [3:0] {
        buck_boot      = 4'h1,
        buck_regulate  = 4'h2,
        buck_ramp_down = 4'h4,
        buck_bypass    = 4'h8
    } buck_state_t;
endpackage
